// File: inc/tia_pkg.sv
// shared constants for the transceiver init, power alarm and loopback control
package tia_pkg;
    // serial port selects
    localparam logic [1:0] PORT_TX_PLL = 2'h1;
    localparam logic [1:0] PORT_RX_PLL = 2'h2;
    localparam logic [1:0] PORT_RXTX = 2'h3;
    // register indices within a port
    localparam logic [2:0] REG_1 = 3'h1;
    localparam logic [2:0] REG_2 = 3'h2;
    localparam logic [2:0] REG_3 = 3'h3;
    localparam logic [2:0] REG_5 = 3'h5;
    // field positions
    localparam int CAL_CLK_HI = 29;
    localparam int CAL_CLK_LO = 27;
    localparam int TX_PD_BIT = 5;
    localparam int LB_EN_BIT = 18;
    localparam int LB_ATT_BIT = 19;
    localparam int REARM_BIT = 20;
    localparam int RAMP_HI = 10;
    localparam int RAMP_LO = 9;
    localparam int GAIN_HI = 15;
    localparam int GAIN_LO = 11;
    // calibration lengths in calibration-clock periods
    localparam logic [3:0] RX_CAL_PERIODS = 4'hc;
    localparam logic [3:0] TX_CAL_PERIODS = 4'hb;
    // reference divider ratios per code
    localparam logic [14:0] CAL_DIV_0 = 15'h0010;
    localparam logic [14:0] CAL_DIV_1 = 15'h0020;
    localparam logic [14:0] CAL_DIV_2 = 15'h0040;
    localparam logic [14:0] CAL_DIV_3 = 15'h0080;
    localparam logic [14:0] CAL_DIV_4 = 15'h0200;
    localparam logic [14:0] CAL_DIV_5 = 15'h0400;
    localparam logic [14:0] CAL_DIV_6 = 15'h0800;
    localparam logic [14:0] CAL_DIV_7 = 15'h412c;
    // reset values
    localparam logic RST_TX_PD = 1'b1;
    localparam logic [15:0] ALARM_TARGET_DEF = 16'h0400;
    // ramp-down time constants
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAMP_US_0 = 28;
    localparam int RAMP_US_1 = 42;
    localparam int RAMP_US_2 = 57;
    localparam int RAMP_US_3 = 75;
    localparam logic [13:0] RAMP_CYC_0 = 14'(RAMP_US_0 * 1000 / CLK_PERIOD_NS);
    localparam logic [13:0] RAMP_CYC_1 = 14'(RAMP_US_1 * 1000 / CLK_PERIOD_NS);
    localparam logic [13:0] RAMP_CYC_2 = 14'(RAMP_US_2 * 1000 / CLK_PERIOD_NS);
    localparam logic [13:0] RAMP_CYC_3 = 14'(RAMP_US_3 * 1000 / CLK_PERIOD_NS);

    typedef enum logic {
        ALARM_MONITOR = 1'b0,
        ALARM_ALERT = 1'b1
    } tia_alarm_e;

    function automatic logic [14:0] tia_cal_ratio(input logic [2:0] code);
        case (code)
            3'h0: tia_cal_ratio = CAL_DIV_0;
            3'h1: tia_cal_ratio = CAL_DIV_1;
            3'h2: tia_cal_ratio = CAL_DIV_2;
            3'h3: tia_cal_ratio = CAL_DIV_3;
            3'h4: tia_cal_ratio = CAL_DIV_4;
            3'h5: tia_cal_ratio = CAL_DIV_5;
            3'h6: tia_cal_ratio = CAL_DIV_6;
            default: tia_cal_ratio = CAL_DIV_7;
        endcase
    endfunction : tia_cal_ratio
endpackage : tia_pkg

// File: hdl/tia_cal_timer.sv
// vco calibration timer counting calibration-clock periods from reference ticks
`timescale 1ns/1ps
module tia_cal_timer #(
    parameter logic [3:0] PERIODS = 4'hc
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [2:0] div_code,
    input wire logic ref_tick,
    output logic busy,
    output logic done
);
    logic [14:0] ratio_q;
    logic [14:0] div_q;
    logic [3:0] per_q;
    logic busy_q;
    logic done_q;
    logic last_div;

    assign last_div = (div_q == ratio_q - 15'h0001);

    // a restart while busy begins a fresh calibration
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ratio_q <= tia_pkg::CAL_DIV_7;
            div_q <= 15'h0000;
            per_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                ratio_q <= tia_pkg::tia_cal_ratio(div_code);
                div_q <= 15'h0000;
                per_q <= 4'h0;
                busy_q <= 1'b1;
            end else if (busy_q && ref_tick) begin
                if (last_div) begin
                    div_q <= 15'h0000;
                    if (per_q == PERIODS - 4'h1) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        per_q <= per_q + 4'h1;
                    end
                end else begin
                    div_q <= div_q + 15'h0001;
                end
            end
        end
    end

    assign busy = busy_q;
    assign done = done_q;
endmodule : tia_cal_timer

// File: hdl/tia_top.sv
// transceiver init sequencing, power alarm and loopback control
//
// Behaviour
// - rx vco calibration ends twelve calibration-clock periods after register 2.
// - calibration clock is reference divided by code in bits 29..27.
// - writes to other ports never disturb a running calibration.
// - tx pll written 4, 5, 1, 2; calibration ends after eleven periods.
// - rx/tx register 5 write starts rx dc-offset calibration.
// - alarm counter counts while flag and alarm high, clears on flag low.
// - counter at target with flag high enters alert, alarm output low.
// - alert holds until bit 20 rises from zero to one.
// - register 3 bits 10..9 choose 28, 42, 57 or 75 us ramp-down.
// - loopback bit 18 closes switch and shuts tx amp, lna, vga1, vga2.
// - register 1 bit 19 selects 20 dB loopback attenuation or minimum loss.
`timescale 1ns/1ps
module tia_top #(
    parameter logic [15:0] ALARM_TARGET = tia_pkg::ALARM_TARGET_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wr_valid,
    input wire logic [1:0] wr_port,
    input wire logic [2:0] wr_reg,
    input wire logic [31:0] wr_data,
    input wire logic ref_clk_in,
    input wire logic below_threshold_flag,
    output logic rx_cal_busy,
    output logic rx_cal_done,
    output logic tx_cal_busy,
    output logic tx_cal_done,
    output logic dc_offset_cal_start,
    output logic transmitter_powerdown,
    output logic power_alarm_out_n,
    output logic [1:0] rampdown_time_sel,
    output logic [13:0] rampdown_cycles,
    output logic loopback_enable,
    output logic loopback_atten_sel,
    output logic tx_amp_off,
    output logic rx_lna_off,
    output logic rx_ifvga1_off,
    output logic rx_ifvga2_off,
    output logic [4:0] rx_baseband_gain_code
);
    ////////////////////////////////////////////////////////////////////////////
    logic ref_s1_q;
    logic ref_s2_q;
    logic ref_prev_q;
    logic ref_tick;
    logic flag_s1_q;
    logic flag_s2_q;

    // pins cross into clk_sys through two flops before use
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            ref_s1_q <= ref_clk_in;
            ref_s2_q <= ref_s1_q;
            ref_prev_q <= ref_s2_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_s1_q <= 1'b0;
            flag_s2_q <= 1'b0;
        end else begin
            flag_s1_q <= below_threshold_flag;
            flag_s2_q <= flag_s1_q;
        end
    end

    // reference must stay below half of clk_sys to be counted edge by edge
    assign ref_tick = ref_s2_q && !ref_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    logic wr_rx_r2;
    logic wr_tx_r2;
    logic wr_c_r1;
    logic wr_c_r2;
    logic wr_c_r3;
    logic wr_c_r5;

    // each port decoded on its own so one port never touches another
    assign wr_rx_r2 = wr_valid && wr_port == tia_pkg::PORT_RX_PLL && wr_reg == tia_pkg::REG_2;
    assign wr_tx_r2 = wr_valid && wr_port == tia_pkg::PORT_TX_PLL && wr_reg == tia_pkg::REG_2;
    assign wr_c_r1 = wr_valid && wr_port == tia_pkg::PORT_RXTX && wr_reg == tia_pkg::REG_1;
    assign wr_c_r2 = wr_valid && wr_port == tia_pkg::PORT_RXTX && wr_reg == tia_pkg::REG_2;
    assign wr_c_r3 = wr_valid && wr_port == tia_pkg::PORT_RXTX && wr_reg == tia_pkg::REG_3;
    assign wr_c_r5 = wr_valid && wr_port == tia_pkg::PORT_RXTX && wr_reg == tia_pkg::REG_5;

    ////////////////////////////////////////////////////////////////////////////
    // calibration is launched only by register 2 of its own port
    tia_cal_timer #(
        .PERIODS(tia_pkg::RX_CAL_PERIODS)
    ) u_rx_cal (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(wr_rx_r2),
        .div_code(wr_data[tia_pkg::CAL_CLK_HI:tia_pkg::CAL_CLK_LO]),
        .ref_tick(ref_tick),
        .busy(rx_cal_busy),
        .done(rx_cal_done)
    );

    tia_cal_timer #(
        .PERIODS(tia_pkg::TX_CAL_PERIODS)
    ) u_tx_cal (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(wr_tx_r2),
        .div_code(wr_data[tia_pkg::CAL_CLK_HI:tia_pkg::CAL_CLK_LO]),
        .ref_tick(ref_tick),
        .busy(tx_cal_busy),
        .done(tx_cal_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic dc_start_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dc_start_q <= 1'b0;
        end else begin
            dc_start_q <= wr_c_r5;
        end
    end

    assign dc_offset_cal_start = dc_start_q;

    ////////////////////////////////////////////////////////////////////////////
    logic tx_pd_q;
    logic lb_en_q;
    logic lb_att_q;
    logic rearm_q;
    logic [1:0] ramp_q;
    logic [13:0] ramp_cyc_q;
    logic [4:0] gain_q;
    logic rearm_rise;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_pd_q <= tia_pkg::RST_TX_PD;
            lb_en_q <= 1'b0;
            lb_att_q <= 1'b0;
            rearm_q <= 1'b0;
        end else if (wr_c_r1) begin
            tx_pd_q <= wr_data[tia_pkg::TX_PD_BIT];
            lb_en_q <= wr_data[tia_pkg::LB_EN_BIT];
            lb_att_q <= wr_data[tia_pkg::LB_ATT_BIT];
            rearm_q <= wr_data[tia_pkg::REARM_BIT];
        end
    end

    // rising bit 20 is judged against the last register 1 write, or the zero loaded at reset
    assign rearm_rise = wr_c_r1 && wr_data[tia_pkg::REARM_BIT] && !rearm_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ramp_q <= 2'h0;
            ramp_cyc_q <= tia_pkg::RAMP_CYC_0;
        end else if (wr_c_r3) begin
            ramp_q <= wr_data[tia_pkg::RAMP_HI:tia_pkg::RAMP_LO];
            case (wr_data[tia_pkg::RAMP_HI:tia_pkg::RAMP_LO])
                2'h0: ramp_cyc_q <= tia_pkg::RAMP_CYC_0;
                2'h1: ramp_cyc_q <= tia_pkg::RAMP_CYC_1;
                2'h2: ramp_cyc_q <= tia_pkg::RAMP_CYC_2;
                default: ramp_cyc_q <= tia_pkg::RAMP_CYC_3;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gain_q <= 5'h00;
        end else if (wr_c_r2) begin
            gain_q <= wr_data[tia_pkg::GAIN_HI:tia_pkg::GAIN_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    tia_pkg::tia_alarm_e alarm_q;
    logic [15:0] alarm_cnt_q;

    // the rearm wins over a same-cycle alert so software is never ignored
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q <= tia_pkg::ALARM_MONITOR;
        end else begin
            unique case (alarm_q)
                tia_pkg::ALARM_MONITOR: begin
                    if (!rearm_rise && flag_s2_q && alarm_cnt_q >= ALARM_TARGET) begin
                        alarm_q <= tia_pkg::ALARM_ALERT;
                    end
                end
                tia_pkg::ALARM_ALERT: begin
                    if (rearm_rise) begin
                        alarm_q <= tia_pkg::ALARM_MONITOR;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alarm_cnt_q <= 16'h0000;
        end else if (rearm_rise || !flag_s2_q) begin
            alarm_cnt_q <= 16'h0000;
        end else if (alarm_q == tia_pkg::ALARM_MONITOR && alarm_cnt_q < ALARM_TARGET) begin
            alarm_cnt_q <= alarm_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign power_alarm_out_n = (alarm_q == tia_pkg::ALARM_MONITOR);
    assign transmitter_powerdown = tx_pd_q;
    assign rampdown_time_sel = ramp_q;
    assign rampdown_cycles = ramp_cyc_q;
    assign loopback_enable = lb_en_q;
    assign loopback_atten_sel = lb_att_q;
    // loopback forces the front end off regardless of other settings
    assign tx_amp_off = tx_pd_q || lb_en_q;
    assign rx_lna_off = lb_en_q;
    assign rx_ifvga1_off = lb_en_q;
    assign rx_ifvga2_off = lb_en_q;
    assign rx_baseband_gain_code = gain_q;
endmodule : tia_top

// File: tb/tia_top_asserts.sv
// concurrent checks on the tia_top ports
`timescale 1ns/1ps
module tia_top_asserts #(
    parameter logic [15:0] ALARM_TARGET = 16'h0400
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wr_valid,
    input wire logic [1:0] wr_port,
    input wire logic [2:0] wr_reg,
    input wire logic [31:0] wr_data,
    input wire logic below_threshold_flag,
    input wire logic rx_cal_busy,
    input wire logic rx_cal_done,
    input wire logic tx_cal_busy,
    input wire logic dc_offset_cal_start,
    input wire logic transmitter_powerdown,
    input wire logic power_alarm_out_n,
    input wire logic [1:0] rampdown_time_sel,
    input wire logic [13:0] rampdown_cycles,
    input wire logic loopback_enable,
    input wire logic loopback_atten_sel,
    input wire logic tx_amp_off,
    input wire logic rx_lna_off,
    input wire logic rx_ifvga1_off,
    input wire logic rx_ifvga2_off
);
    logic arm_q;
    logic [15:0] hi_q;
    logic wr1;
    logic wr3;
    logic rearm;
    assign wr1 = wr_valid && wr_port == tia_pkg::PORT_RXTX && wr_reg == tia_pkg::REG_1;
    assign wr3 = wr_valid && wr_port == tia_pkg::PORT_RXTX && wr_reg == tia_pkg::REG_3;
    assign rearm = wr1 && wr_data[20] && !arm_q;
    // stored rearm bit, only a rising write counts
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) arm_q <= 1'b0;
        else if (wr1) arm_q <= wr_data[20];
    end
    // raw flag run length; saturates so a long run never wraps
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) hi_q <= 16'h0;
        else if (!below_threshold_flag) hi_q <= 16'h0;
        else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h1;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_rx_go;
        wr_valid && wr_port == tia_pkg::PORT_RX_PLL && wr_reg == tia_pkg::REG_2;
    endsequence
    sequence s_tx_go;
        wr_valid && wr_port == tia_pkg::PORT_TX_PLL && wr_reg == tia_pkg::REG_2;
    endsequence
    a_rx_cal_start: assert property (s_rx_go |=> rx_cal_busy)
        else $error("rx calibration did not start");
    a_tx_cal_start: assert property (s_tx_go |=> tx_cal_busy)
        else $error("tx calibration did not start");
    a_rx_done_ends: assert property (rx_cal_done |-> !rx_cal_busy && $past(rx_cal_busy))
        else $error("rx done without busy ending");
    a_dc_cal_start: assert property (wr_valid && wr_port == tia_pkg::PORT_RXTX
        && wr_reg == tia_pkg::REG_5 |=> dc_offset_cal_start)
        else $error("dc offset start missing");
    a_pwd_follows: assert property (wr1 |=> transmitter_powerdown == $past(wr_data[5]))
        else $error("powerdown bit not taken");
    a_lb_fields: assert property (wr1 |=> loopback_atten_sel == $past(wr_data[19])
        && loopback_enable == $past(wr_data[18]))
        else $error("loopback fields not taken");
    a_lb_shutdown: assert property (loopback_enable |-> tx_amp_off && rx_lna_off
        && rx_ifvga1_off && rx_ifvga2_off)
        else $error("loopback left a stage on");
    a_ramp_select: assert property (wr3 |=> rampdown_time_sel == $past(wr_data[10:9]))
        else $error("ramp select not taken");
    a_ramp_map: assert property (rampdown_cycles == 14'(100 * (rampdown_time_sel == 2'h0 ? 28
        : rampdown_time_sel == 2'h1 ? 42 : rampdown_time_sel == 2'h2 ? 57 : 75)))
        else $error("ramp time wrong for select");
    a_alert_time: assert property ($fell(power_alarm_out_n) |-> hi_q >= ALARM_TARGET)
        else $error("alert before flag run reached target");
    a_alert_hold: assert property (!power_alarm_out_n && !rearm |=> !power_alarm_out_n)
        else $error("alert released without rearm");
    a_rearm_release: assert property (rearm |=> power_alarm_out_n)
        else $error("rearm did not release alarm");
endmodule : tia_top_asserts

// File: tb/tia_host.sv
// host model issuing decoded port writes and the free reference clock
`timescale 1ns/1ps
module tia_host (
    input wire logic clk_sys,
    output logic wr_valid,
    output logic [1:0] wr_port,
    output logic [2:0] wr_reg,
    output logic [31:0] wr_data,
    output logic ref_clk_in
);
    initial begin
        wr_valid = 1'b0;
        wr_port = 2'h0;
        wr_reg = 3'h0;
        wr_data = 32'h0;
        ref_clk_in = 1'b0;
        #3;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // entered just after an edge, returns just after the taking edge
    task automatic wr(input logic [1:0] p, input logic [2:0] r, input logic [31:0] d);
        wr_valid = 1'b1;
        wr_port = p;
        wr_reg = r;
        wr_data = d;
        @(posedge clk_sys);
        #1;
    endtask : wr
    // released fields show inverted junk, never the last word
    task automatic idle();
        wr_valid = 1'b0;
        wr_port = ~wr_port;
        wr_reg = ~wr_reg;
        wr_data = ~wr_data;
    endtask : idle
    // regs 4, 5, 1, then 2 last since it launches calibration
    // 25 MHz ref over ratio 32 or more keeps cal clock under 800 kHz
    task automatic pll_init(input logic [1:0] p, input logic [2:0] code, input logic [15:0] n);
        wr(p, 3'h4, 32'h0);
        wr(p, 3'h5, 32'h0);
        wr(p, 3'h1, 32'h0000_0020); // r divide 1
        wr(p, 3'h2, {2'h3, code, 6'h0, n, 5'h0}); // lo divide-by-16 select 0
    endtask : pll_init
    // order 6, 3, 7, 4, 2, 5, 1, 1
    task automatic rxtx_init(input logic [1:0] ramp, input logic [31:0] r1);
        wr(2'h3, 3'h6, 32'h0);
        wr(2'h3, 3'h3, {21'h0, ramp, 9'h0});
        wr(2'h3, 3'h7, 32'h0);
        wr(2'h3, 3'h4, 32'h0);
        wr(2'h3, 3'h2, 32'h0000_0800); // gain code 00001
        wr(2'h3, 3'h5, 32'h0);
        wr(2'h3, 3'h1, r1); // transmitter enabled last
        wr(2'h3, 3'h1, r1 | 32'h0010_0000); // resend to arm alarm
        idle();
    endtask : rxtx_init
endmodule : tia_host

// File: tb/transceiver_init_power_alarm_test.sv
// self-checking bench for tia_top
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module transceiver_init_power_alarm_test;
    localparam logic [15:0] TGT = 16'h0008;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic below_threshold_flag = 1'b0;
    logic wr_valid, ref_clk_in, rx_cal_busy, rx_cal_done, tx_cal_busy, tx_cal_done;
    logic dc_offset_cal_start, transmitter_powerdown, power_alarm_out_n;
    logic loopback_enable, loopback_atten_sel, tx_amp_off, rx_lna_off;
    logic rx_ifvga1_off, rx_ifvga2_off;
    logic [1:0] wr_port, rampdown_time_sel;
    logic [2:0] wr_reg;
    logic [31:0] wr_data;
    logic [13:0] rampdown_cycles;
    logic [4:0] rx_baseband_gain_code;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int dc_cnt = 0;
    tia_host host (.clk_sys, .wr_valid, .wr_port, .wr_reg, .wr_data, .ref_clk_in);
    tia_top #(.ALARM_TARGET(TGT)) dut (.clk_sys, .arst_n, .wr_valid, .wr_port, .wr_reg,
        .wr_data, .ref_clk_in, .below_threshold_flag, .rx_cal_busy, .rx_cal_done,
        .tx_cal_busy, .tx_cal_done, .dc_offset_cal_start, .transmitter_powerdown,
        .power_alarm_out_n, .rampdown_time_sel, .rampdown_cycles, .loopback_enable,
        .loopback_atten_sel, .tx_amp_off, .rx_lna_off, .rx_ifvga1_off, .rx_ifvga2_off,
        .rx_baseband_gain_code);
    always #5 clk_sys = ~clk_sys;
    // ceiling well above the longest calibration the bench waits out
    always @(posedge clk_sys) begin
        cyc++;
        if (dc_offset_cal_start === 1'b1) dc_cnt++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("reset_pd", 2'h3, {transmitter_powerdown, tx_amp_off})
        `CHK("reset_alarm", 1'b1, power_alarm_out_n)
        `CHK("reset_idle", 3'h0, {rx_cal_busy, loopback_enable, dc_offset_cal_start})
        `CHK("reset_ramp", 14'd2800, rampdown_cycles)
    endtask : t_reset
    // rx then tx four cycles later; both run to their own lengths
    task automatic t_cal();
        int t0, t1, rx_t, tx_t;
        host.pll_init(2'h2, 3'h1, 16'd132);
        t0 = cyc;
        host.pll_init(2'h1, 3'h2, 16'd66);
        t1 = cyc;
        host.idle();
        `CHK("rx_busy", 1'b1, rx_cal_busy)
        rx_t = 0;
        tx_t = 0;
        for (int i = 0; i < 3200 && tx_t == 0; i++) begin
            step(1);
            if (rx_cal_done === 1'b1) rx_t = cyc;
            if (tx_cal_done === 1'b1) tx_t = cyc;
        end
        // ref period is four clocks; allow phase and sync slack
        rx_t -= t0;
        tx_t -= t1;
        // one period is ratio 32 or 64 times four clocks per ref edge
        `CHK("rx_cal_len", 1'b1, rx_t > 12 * 128 - 7 && rx_t < 12 * 128 + 7)
        `CHK("tx_cal_len", 1'b1, tx_t > 11 * 256 - 7 && tx_t < 11 * 256 + 7)
        // code 7 must outlast a code 1 run; its full length is too long to wait out
        host.pll_init(2'h2, 3'h7, 16'd132);
        host.idle();
        step(12 * 128 + 8);
        `CHK("rx_cal_slow", 1'b1, rx_cal_busy)
    endtask : t_cal
    task automatic t_init();
        host.rxtx_init(2'h2, 32'h0);
        `CHK("dc_start_pulses", 1, dc_cnt)
        `CHK("tx_enabled", 1'b0, transmitter_powerdown)
        `CHK("gain_code", 5'h01, rx_baseband_gain_code)
    endtask : t_init
    task automatic t_ramp();
        int us[4] = '{28, 42, 57, 75};
        step(1);
        for (int k = 0; k < 4; k++) begin
            host.wr(2'h3, 3'h3, {21'h0, k[1:0], 9'h0});
            `CHK("ramp_sel", k[1:0], rampdown_time_sel)
            `CHK("ramp_cyc", 14'(us[k] * 100), rampdown_cycles)
        end
        host.idle();
    endtask : t_ramp
    task automatic t_loop();
        logic [6:0] seen;
        step(1);
        for (int k = 0; k < 8; k++) begin
            host.wr(2'h3, 3'h1, {11'h0, 1'b1, k[1], k[0], 12'h0, k[2], 5'h0});
            seen = {transmitter_powerdown, loopback_atten_sel, loopback_enable, tx_amp_off,
                rx_lna_off, rx_ifvga1_off, rx_ifvga2_off};
            `CHK("lb_fields", {k[2], k[1], k[0]}, seen[6:4])
            `CHK("lb_shutdown", {k[2] | k[0], k[0], k[0], k[0]}, seen[3:0])
        end
        host.idle();
    endtask : t_loop
    task automatic t_alarm();
        logic low = 1'b0;
        below_threshold_flag = 1'b1;
        step(TGT - 2);
        below_threshold_flag = 1'b0;
        step(3);
        below_threshold_flag = 1'b1;
        for (int i = 0; i < TGT; i++) begin
            step(1);
            if (power_alarm_out_n !== 1'b1) low = 1'b1;
        end
        `CHK("alarm_cleared_run", 1'b0, low)
        for (int i = 0; i < 20 && power_alarm_out_n !== 1'b0; i++) step(1);
        `CHK("alarm_fell", 1'b0, power_alarm_out_n)
        host.wr(2'h3, 3'h1, 32'h0010_0000);
        host.idle();
        step(2);
        `CHK("alarm_held", 1'b0, power_alarm_out_n)
        host.wr(2'h3, 3'h1, 32'h0);
        host.wr(2'h3, 3'h1, 32'h0010_0000);
        host.idle();
        `CHK("alarm_rearmed", 1'b1, power_alarm_out_n)
        step(TGT - 2);
        `CHK("count_restarted", 1'b1, power_alarm_out_n)
        below_threshold_flag = 1'b0;
    endtask : t_alarm
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        t_reset();
        arst_n = 1'b1;
        t_cal();
        t_init();
        t_ramp();
        t_loop();
        t_alarm();
        stop_test();
    end
endmodule : transceiver_init_power_alarm_test
bind tia_top tia_top_asserts #(.ALARM_TARGET(ALARM_TARGET)) u_chk (.clk_sys, .arst_n,
    .wr_valid, .wr_port, .wr_reg, .wr_data, .below_threshold_flag, .rx_cal_busy,
    .rx_cal_done, .tx_cal_busy, .dc_offset_cal_start, .transmitter_powerdown,
    .power_alarm_out_n, .rampdown_time_sel, .rampdown_cycles, .loopback_enable,
    .loopback_atten_sel, .tx_amp_off, .rx_lna_off, .rx_ifvga1_off, .rx_ifvga2_off);
